//--- core/asc_ctrl.sv
/*
  Host-side controller for an asynchronous 256K x 4 static RAM.
  Takes single-word read and write requests on a valid/ready port and
  sequences chip select, output enable, write enable, address and the
  bidirectional data pins. Assumes the memory's pins are wired straight to
  these ports and that the pin level is resolved outside from data_oe.
*/
`timescale 1ns/10ps

// Overview of operation
// RL1 - reads use select low, output enable low, write enable high
// RL2 - writes drive data while select and write enable are both low
// RL3 - idle selected state with both enables high leaves pins undriven
// RL4 - select held high between accesses keeps memory in standby
// RL5 - a write lasts only while select and write enable overlap low
// RL6 - address changes only while write enable or select is high
// RL7 - select falls before write enable so memory never drives
// RL8 - write pulse covers high-z delay plus output-active time
// RL9 - controller drives data only after memory has released the pins
// RL10 - address is set on the same edge select falls, so address access time governs
// RL11 - successive reads are spaced by the minimum read cycle
// RL12 - read data sampled no earlier than address access time
// RL13 - read data sampled no earlier than output enable access time
// RL14 - read data captured before address moves on
// RL15 - successive writes are spaced by the minimum write cycle
// RL16 - write enable held low at least the minimum pulse width
// RL17 - write data valid the setup time before write ends, zero hold
// RL18 - controller waits the write high-z delay before driving data
// RL19 - memory holds 256K words of 4 bits on a shared data port
// RL20 - address is 18 bits; no refresh activity is ever issued
module asc_ctrl
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // request port
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic [asc_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [asc_pkg::DATA_W-1:0]  req_wdata,
  // read answer
  output logic                             rsp_valid,
  output logic [asc_pkg::DATA_W-1:0]       rsp_rdata,
  // memory pins
  output logic                             mem_cs_n,
  output logic                             mem_oe_n,
  output logic                             mem_we_n,
  output logic [asc_pkg::ADDR_W-1:0]       mem_addr,
  input  wire logic [asc_pkg::DATA_W-1:0]  data_in,
  output logic [asc_pkg::DATA_W-1:0]       data_out,
  output logic                             data_oe
);
  import asc_pkg::*;

  localparam logic [CNT_W-1:0] RD_ACC = CNT_W'(RD_ACCESS_CYC);
  localparam logic [CNT_W-1:0] RD_REC = CNT_W'((RD_CYCLE_CYC > RD_ACCESS_CYC) ?
                                               (RD_CYCLE_CYC - RD_ACCESS_CYC) : 1);
  localparam logic [CNT_W-1:0] WR_HZ  = CNT_W'(HZ_CYC);
  localparam logic [CNT_W-1:0] WR_PUL = CNT_W'((WP_CYC > DW_CYC) ? WP_CYC : DW_CYC);
  localparam logic [CNT_W-1:0] WR_REC = CNT_W'((WC_CYC > HZ_CYC + WP_CYC) ?
                                               (WC_CYC - HZ_CYC - WP_CYC) : 1);

  logic rst_n;

  asc_rst_sync asc_rst_sync_inst (
    .clk        (clk),
    .resetn     (resetn),
    .rst_sync_n (rst_n)
  );

  asc_state_e            state_q, state_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic                  cs_n_q, cs_n_d;
  logic                  oe_n_q, oe_n_d;
  logic                  we_n_q, we_n_d;
  logic                  doe_q, doe_d;
  logic [ADDR_W-1:0]     addr_q, addr_d;
  logic [DATA_W-1:0]     wdata_q, wdata_d;
  logic [DATA_W-1:0]     rdata_q, rdata_d;
  logic                  rsp_q, rsp_d;
  logic                  cnt_done;

  assign cnt_done  = (cnt_q == CNT_ONE);
  assign req_ready = (state_q == ASC_IDLE);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = (cnt_q == CNT_ZERO) ? CNT_ZERO : cnt_q - CNT_ONE;
    cs_n_d  = cs_n_q;
    oe_n_d  = oe_n_q;
    we_n_d  = we_n_q;
    doe_d   = doe_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d   = 1'b0;
    unique case (state_q)
      ASC_IDLE:
      begin
        // standby: select high, enables high, pins undriven
        cs_n_d = 1'b1; // see RL4
        oe_n_d = 1'b1; // see RL3
        we_n_d = 1'b1;
        doe_d  = 1'b0;
        if (req_valid)
        begin
          // address moves only while write enable is high
          addr_d  = req_addr; // see RL6
          wdata_d = req_wdata;
          if (req_write)
          begin
            // select falls now, write enable one edge later
            cs_n_d  = 1'b0; // see RL7
            oe_n_d  = 1'b1;
            state_d = ASC_WRHZ;
            cnt_d   = WR_HZ; // see RL18
          end
          else
          begin
            // address and select change on the same edge, so address access time governs
            cs_n_d  = 1'b0; // see RL10
            oe_n_d  = 1'b0; // see RL1
            state_d = ASC_RD;
            cnt_d   = RD_ACC; // see RL12
          end
        end
      end
      ASC_RD:
      begin
        if (cnt_done)
        begin
          // capture before the address or select can move
          rdata_d = data_in; // see RL13
          rsp_d   = 1'b1; // see RL14
          cs_n_d  = 1'b1;
          oe_n_d  = 1'b1;
          state_d = ASC_RDREC;
          cnt_d   = RD_REC; // see RL11
        end
      end
      ASC_RDREC:
      begin
        if (cnt_done)
          state_d = ASC_IDLE;
      end
      ASC_WRHZ:
      begin
        // oe is high so memory never drives; still wait out high-z time
        if (cnt_done)
        begin
          we_n_d  = 1'b0; // see RL2
          doe_d   = 1'b1; // see RL9
          state_d = ASC_WR;
          cnt_d   = WR_PUL; // see RL16 RL8 RL17
        end
      end
      ASC_WR:
      begin
        if (cnt_done)
        begin
          // end write on both edges together; data removed with zero hold
          we_n_d  = 1'b1; // see RL5
          cs_n_d  = 1'b1;
          doe_d   = 1'b0;
          state_d = ASC_WRREC;
          cnt_d   = WR_REC; // see RL15
        end
      end
      ASC_WRREC:
      begin
        if (cnt_done)
          state_d = ASC_IDLE;
      end
      default:
      begin
        state_d = ASC_IDLE;
      end
    endcase
  end

  // no refresh: memory is static, state only leaves ASC_IDLE on a request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ASC_IDLE;
      cnt_q   <= CNT_ZERO;
      cs_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      doe_q   <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cs_n_q  <= cs_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      doe_q   <= doe_d;
      addr_q  <= addr_d; // see RL20 RL19
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q   <= rsp_d;
    end
  end

  assign mem_cs_n  = cs_n_q;
  assign mem_oe_n  = oe_n_q;
  assign mem_we_n  = we_n_q;
  assign mem_addr  = addr_q;
  assign data_out  = wdata_q;
  assign data_oe   = doe_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;

endmodule

//--- core/asc_pkg.sv
/*
  Package for the host-side controller of an asynchronous 256K x 4 static RAM.
  Holds the geometry, the timing figures of the selected speed grade and the
  controller state encoding. Assumes a 25 MHz controller clock.
*/
package asc_pkg;

  // geometry
  localparam int ADDR_W    = 18;
  localparam int DATA_W    = 4;
  localparam int WORDS     = 262144;

  // clock
  localparam int CLK_PS    = 40000;

  // speed grade figures, in ns (slowest grade, safe for all parts)
  localparam int READ_CYCLE_MIN_NS               = 25;
  localparam int ADDRESS_ACCESS_MAX_NS           = 25;
  localparam int OUTPUT_ENABLE_ACCESS_MAX_NS     = 10;
  localparam int OUTPUT_HOLD_MIN_NS              = 4;
  localparam int WRITE_CYCLE_MIN_NS              = 25;
  localparam int WRITE_PULSE_MIN_NS              = 15;
  localparam int WRITE_DATA_SETUP_MIN_NS         = 10;
  localparam int WRITE_TO_HIGH_Z_MAX_NS          = 9;
  localparam int OUTPUT_ACTIVE_AFTER_WRITE_MIN_NS = 4;

  // cycle counts: least times round up, longest settle waits too
  localparam int unsigned RD_ACCESS_NS =
    (ADDRESS_ACCESS_MAX_NS > OUTPUT_ENABLE_ACCESS_MAX_NS) ?
    ADDRESS_ACCESS_MAX_NS : OUTPUT_ENABLE_ACCESS_MAX_NS;
  localparam int unsigned RD_ACCESS_CYC  = (RD_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RD_CYCLE_CYC   = (READ_CYCLE_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WP_OE_LOW_NS   =
    WRITE_TO_HIGH_Z_MAX_NS + OUTPUT_ACTIVE_AFTER_WRITE_MIN_NS;
  localparam int unsigned WP_NS          =
    (WRITE_PULSE_MIN_NS > WP_OE_LOW_NS) ? WRITE_PULSE_MIN_NS : WP_OE_LOW_NS;
  localparam int unsigned WP_CYC         = (WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned DW_CYC         =
    (WRITE_DATA_SETUP_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WC_CYC         = (WRITE_CYCLE_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HZ_CYC         =
    (WRITE_TO_HIGH_Z_MAX_NS * 1000 + CLK_PS - 1) / CLK_PS;

  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  typedef enum logic [2:0] {
    ASC_IDLE  = 3'b000,
    ASC_RD    = 3'b001,
    ASC_RDREC = 3'b010,
    ASC_WRHZ  = 3'b011,
    ASC_WR    = 3'b100,
    ASC_WRREC = 3'b101
  } asc_state_e;

endpackage

//--- core/asc_rst_sync.sv
/*
  Reset release synchroniser for the SRAM controller.
  Assumes an active-low asynchronous reset and a free running clock.
*/
`timescale 1ns/10ps
module asc_rst_sync (
  // clock and raw reset
  input  wire logic clk,
  input  wire logic resetn,
  // released copy
  output logic      rst_sync_n
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = 1'b1;
    sync_d = meta_q;
  end

  // assert asynchronously, release after two edges
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign rst_sync_n = sync_q;

endmodule

//--- tb/asc_chk.sv
/* Assertions on the SRAM controller's ports.
   Bound into asc_ctrl by the bench top; one clock domain. */
`timescale 1ns/10ps
module asc_chk
  import asc_pkg::*;
(
  // request side
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       req_valid,
  input wire logic                       req_ready,
  input wire logic                       req_write,
  input wire logic                       rsp_valid,
  // memory side
  input wire logic                       mem_cs_n,
  input wire logic                       mem_oe_n,
  input wire logic                       mem_we_n,
  input wire logic [asc_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                       data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_rd_on; !mem_cs_n && !mem_oe_n && mem_we_n && !data_oe; endsequence
  sequence s_wr_sel; !mem_cs_n && mem_we_n && mem_oe_n && !data_oe; endsequence
  sequence s_wr_pul; !mem_cs_n && !mem_we_n && mem_oe_n && data_oe; endsequence
  property p_rd_walk; s_take ##0 !req_write |-> ##[1:2] s_rd_on ##1 (mem_cs_n && rsp_valid);
  endproperty
  a_rd_walk: assert property (p_rd_walk) else $error("read strobes or answer out of order");
  property p_rsp_src; rsp_valid |-> !$past(mem_cs_n) && !$past(mem_oe_n); endproperty
  a_rsp_src: assert property (p_rsp_src) else $error("answer without a selected read");
  property p_wr_walk; s_take ##0 req_write |-> ##[1:2] s_wr_sel ##1 s_wr_pul ##1 mem_we_n;
  endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("write strobes out of order");
  property p_addr; $changed(mem_addr) |-> (mem_cs_n || mem_we_n) && ($past(mem_cs_n) ||
    $past(mem_we_n)); endproperty
  a_addr: assert property (p_addr) else $error("address moved inside a write");
  property p_no_clash; data_oe |-> mem_oe_n && !mem_we_n; endproperty
  a_no_clash: assert property (p_no_clash) else $error("data driven while memory may drive");
  property p_wr_end; $rose(mem_we_n) |-> $rose(mem_cs_n) && $past(data_oe) && !data_oe; endproperty
  a_wr_end: assert property (p_wr_end) else $error("write end not clean");
  property p_busy; s_take |=> !req_ready [*2]; endproperty
  a_busy: assert property (p_busy) else $error("accesses spaced too closely");
  property p_idle; req_ready |-> mem_cs_n && mem_oe_n && mem_we_n && !data_oe; endproperty
  a_idle: assert property (p_idle) else $error("pins active while idle");
endmodule

//--- tb/asc_ctrl_test.sv
/* Bench top: controller, behavioural memory and bound checker.
   Assumes asc_chk and asc_sram_model are compiled first. */
`timescale 1ns/10ps
module asc_ctrl_test;
  import asc_pkg::*;
  logic              clk, resetn, req_valid, req_write, req_ready, rsp_valid;
  logic              cs_n, oe_n, we_n, data_oe;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, data_out, mem_dq;
  wire  [DATA_W-1:0] pin;
  int                mismatches = 0, n_checks = 0, cycles = 0;
  assign pin = data_oe ? data_out : mem_dq;
  asc_ctrl asc_ctrl_inst (.clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_cs_n(cs_n), .mem_oe_n(oe_n),
    .mem_we_n(we_n), .mem_addr(mem_addr), .data_in(pin), .data_out(data_out),
    .data_oe(data_oe));
  asc_sram_model asc_sram_model_inst (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .addr(mem_addr), .pin(pin), .dq(mem_dq));
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request stays up until an edge sees ready; caller lowers it
  task automatic send(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check("request taken", n < 20, 1'b1);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    send(1'b0, a, 4'h0);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    check("rsp_valid", rsp_valid, 1'b1);
    check("rsp_rdata", rsp_rdata, exp);
    @(posedge clk);
    check("rsp_valid drop", rsp_valid, 1'b0);
  endtask
  task automatic t_values;
    for (int i = 0; i < 16; i++)
      send(1'b1, {i[3:0], {14{i[0]}}}, i[3:0]);
    for (int i = 0; i < 16; i++)
      rd({i[3:0], {14{i[0]}}}, i[3:0]);
  endtask
  task automatic t_neighbours;
    send(1'b1, 18'h12344, 4'h9);
    send(1'b1, 18'h12345, 4'h3);
    send(1'b1, 18'h12345, 4'he);
    send(1'b1, 18'h12346, 4'h6);
    rd(18'h12345, 4'he);
    rd(18'h12344, 4'h9);
    rd(18'h12346, 4'h6);
  endtask
  task automatic t_strobes;
    int lows;
    lows = 0;
    send(1'b1, 18'h2aaaa, 4'ha);
    req_valid <= 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      if (we_n === 1'b0)
      begin
        lows++;
        check("pins in pulse", {cs_n, oe_n, data_oe, pin}, {3'h3, 4'ha});
        check("addr in pulse", mem_addr, 18'h2aaaa);
      end
    end
    check("pulse cycles", lows, WP_CYC);
  endtask
  task automatic t_reset_mid;
    send(1'b1, 18'h15555, 4'h5);
    req_valid <= 1'b0;
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    check("pins in reset", {cs_n, oe_n, we_n, data_oe, req_ready, rsp_valid}, 6'h3a);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(18'h12344, 4'h9);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 18'h0;
    req_wdata = 4'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check("idle pins", {cs_n, oe_n, we_n, data_oe, req_ready, rsp_valid}, 6'h3a);
    t_values;
    t_neighbours;
    t_strobes;
    t_reset_mid;
    summarize;
  end
  // ceiling well above the roughly 190 cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      summarize;
    end
  end
endmodule
bind asc_ctrl asc_chk asc_chk_inst (.clk(clk), .resetn(resetn), .req_valid(req_valid),
  .req_ready(req_ready), .req_write(req_write), .rsp_valid(rsp_valid), .mem_cs_n(mem_cs_n),
  .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_addr(mem_addr), .data_oe(data_oe));

//--- tb/asc_sram_model.sv
/* Behavioural 256K x 4 asynchronous static RAM.
   Assumes the bench resolves the shared data wire into pin. */
`timescale 1ns/10ps
module asc_sram_model
  import asc_pkg::*;
#(
  parameter int ACC_NS = 25
)
(
  // control and address
  input  wire logic                       cs_n,
  input  wire logic                       oe_n,
  input  wire logic                       we_n,
  input  wire logic [asc_pkg::ADDR_W-1:0] addr,
  // data wire in, own drive out
  input  wire logic [asc_pkg::DATA_W-1:0] pin,
  output logic      [asc_pkg::DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] last;
  logic              ready;
  logic              drive;
  // slowest answer: data valid only once the access time has run
  assign #(ACC_NS) ready = !cs_n && !oe_n && we_n;
  logic [DATA_W-1:0] pin_late;
  // zero-hold release lands in the same step as the strobe rise; look a little late
  assign #1 pin_late = pin;
  always @(cs_n or we_n or addr or pin_late)
    if (!cs_n && !we_n)
      mem[addr] = pin_late;
  always @(cs_n or oe_n or we_n or addr or ready)
  begin
    drive = ready && !cs_n && !oe_n && we_n;
    if (drive)
      last = mem[addr];
    // released wire shows the inverse, so a stale word never passes
    dq = drive ? last : ~last;
  end
endmodule
